// ### inc/tdm_port_pkg.sv
package tdm_port_pkg;
    typedef enum logic [1:0] {
        MODE_2X32 = 2'h0,
        MODE_1X6 = 2'h1,
        MODE_1X12 = 2'h2,
        MODE_1X64 = 2'h3
    } port_mode_t;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL = 16'h0000;
    localparam logic [15:0] IDX_PREFIX = 16'h0001;
    localparam logic [15:0] IDX_STATUS = 16'h0002;
    localparam logic [15:0] IDX_WIN_FIRST = 16'h8000;
    localparam logic [15:0] IDX_WIN_LAST = 16'h807f;

    localparam logic [6:0] TX_BASE = 7'h40;
    localparam logic [6:0] PORT1_OFS = 7'h20;
    localparam int CTRL_DBL = 2;
    localparam int STAT_LOCK = 1;
    localparam int STAT_OVR = 2;
    localparam port_mode_t MODE_RESET = MODE_2X32;
    localparam logic [7:0] PREFIX_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [9:0] PH_AFTER_SYNC = 10'h001;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 16;

    function automatic logic [9:0] frame_bits(port_mode_t m);
        case (m)
            MODE_1X6: frame_bits = 10'h030;
            MODE_1X12: frame_bits = 10'h060;
            MODE_1X64: frame_bits = 10'h200;
            default: frame_bits = 10'h100;
        endcase
    endfunction : frame_bits

    function automatic logic [9:0] last_phase(port_mode_t m, logic dbl);
        logic [9:0] b;
        b = frame_bits(m);
        last_phase = (dbl ? {b[8:0], 1'b0} : b) - 10'h001;
    endfunction : last_phase

    function automatic logic [6:0] slot_addr(port_mode_t m, logic port,
                                             logic tx, logic [5:0] slot);
        slot_addr = {1'b0, slot} + (tx ? TX_BASE : 7'h00)
                  + ((port && m == MODE_2X32) ? PORT1_OFS : 7'h00);
    endfunction : slot_addr
endpackage : tdm_port_pkg

// ### tb/tb_tdm_port_frame_double_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_tdm_port_frame_double_buffer;
    logic I_MCLK = 1'b0;
    logic I_ARST_N = 1'b0;
    logic I_PSEL = 1'b0;
    logic I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [17:0] I_PADDR = 18'h00000;
    logic [31:0] I_PWDATA = 32'h00000000;
    logic [31:0] O_PRDATA;
    logic O_PREADY, O_PSLVERR, bclk, fsync, up0, up1, dd0, dd1, oe0_n, oe1_n;
    logic run = 1'b0;
    logic dbl = 1'b0;
    logic [9:0] nbits = 10'h030;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [32:0] apb_q[$];
    logic [15:0] ser_q[$];
    // Released downstream lines are pulled up
    wire logic dd0_w = oe0_n ? 1'b1 : dd0;
    wire logic dd1_w = oe1_n ? 1'b1 : dd1;

    tdm_port_frame_double_buffer u_tdm_port_frame_double_buffer (
        .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
        .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR), .I_BIT_CLOCK(bclk), .I_FRAME_SYNC(fsync),
        .I_UPSTREAM_DATA_0(up0), .I_UPSTREAM_DATA_1(up1),
        .O_DOWNSTREAM_DATA_0(dd0), .O_DOWNSTREAM_DATA_0_OE_N(oe0_n),
        .O_DOWNSTREAM_DATA_1(dd1), .O_DOWNSTREAM_DATA_1_OE_N(oe1_n));
    tdm_far_side u_tdm_far_side (.o_bit_clock(bclk), .o_frame_sync(fsync),
        .o_up0(up0), .o_up1(up1), .i_dd0(dd0_w), .i_dd1(dd1_w),
        .i_run(run), .i_dbl(dbl), .i_nbits(nbits));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    initial begin
        forever #50 I_MCLK = ~I_MCLK;
    end

    // The run needs about 40k cycles; the ceiling leaves over twice that
    always @(posedge I_MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            give_verdict();
        end
    end

    always @(posedge I_MCLK) begin
        if (I_PSEL && I_PENABLE && O_PREADY === 1'b1 && apb_q.size() != 0)
            check({O_PSLVERR, O_PRDATA}, apb_q.pop_front());
    end

    // Bytes of frames with no notes queued are ignored
    always @(posedge I_MCLK) begin
        logic [15:0] c;
        if (u_tdm_far_side.cap_q.size() != 0) begin
            c = u_tdm_far_side.cap_q.pop_front();
            if (ser_q.size() != 0)
                check({17'h0, c}, {17'h0, ser_q.pop_front()});
        end
    end

    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [31:0] d, input logic [32:0] e);
        apb_q.push_back(e);
        I_PSEL <= 1'b1;
        I_PWRITE <= w;
        I_PADDR <= {idx, 2'b00};
        I_PWDATA <= d;
        I_PENABLE <= 1'b0;
        @(posedge I_MCLK);
        I_PENABLE <= 1'b1;
        @(posedge I_MCLK);
        while (O_PREADY !== 1'b1) @(posedge I_MCLK);
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
        @(posedge I_MCLK);
    endtask : apb

    function automatic logic [15:0] widx(input logic t, input logic p,
                                         input int k);
        return tdm_port_pkg::IDX_WIN_FIRST + 16'(k)
            + (t ? 16'(tdm_port_pkg::TX_BASE) : 16'h0000)
            + (p ? 16'(tdm_port_pkg::PORT1_OFS) : 16'h0000);
    endfunction : widx

    task automatic run_mode(input tdm_port_pkg::port_mode_t m,
                            input logic d, input int ns);
        logic [7:0] pre;
        logic [7:0] tx[2][64];
        int f;
        int np;
        np = (m == tdm_port_pkg::MODE_2X32) ? 2 : 1;
        pre = 8'($urandom);
        apb(1'b1, tdm_port_pkg::IDX_CTRL, {29'h0, d, m}, 33'h0);
        apb(1'b1, tdm_port_pkg::IDX_PREFIX, {24'h0, pre}, 33'h0);
        nbits <= 10'(ns * 8);
        dbl <= d;
        run <= 1'b1;
        repeat (3) @(u_tdm_far_side.fstart);
        repeat (40) @(posedge I_MCLK);
        check({32'h0, oe1_n}, {32'h0, np == 1});
        check({32'h0, oe0_n}, 33'h0);
        f = u_tdm_far_side.frame;
        for (int k = 0; k < ns; k++) begin
            for (int p = 0; p < np; p++) begin
                tx[p][k] = 8'($urandom);
                // High bits are random and must not reach the wire
                apb(1'b1, widx(1'b1, 1'(p), k), {24'($urandom), tx[p][k]},
                    33'h0);
            end
        end
        apb(1'b1, widx(1'b0, 1'b0, 0), $urandom, 33'h0);
        for (int k = 0; k < ns; k++) begin
            for (int p = 0; p < np; p++)
                apb(1'b0, widx(1'b0, 1'(p), k), 32'h0, {17'h0, pre,
                    u_tdm_far_side.upb(f - 1, k, 1'(p))});
        end
        @(u_tdm_far_side.fstart);
        for (int k = 0; k < ns; k++)
            ser_q.push_back({np == 2 ? tx[1][k] : 8'hff, tx[0][k]});
        @(u_tdm_far_side.fstart);
        // Frame events fall between clock edges; realign the bus master
        @(posedge I_MCLK);
        check(33'(ser_q.size()), 33'h0);
    endtask : run_mode

    initial begin
        void'($urandom(32'hafb775fb));
        repeat (10) @(posedge I_MCLK);
        check({32'h0, oe0_n}, 33'h1);
        I_ARST_N <= 1'b1;
        @(posedge I_MCLK);
        apb(1'b0, tdm_port_pkg::IDX_CTRL, 32'h0, 33'h0);
        apb(1'b0, tdm_port_pkg::IDX_PREFIX, 32'h0, 33'h0);
        apb(1'b0, tdm_port_pkg::IDX_STATUS, 32'h0, 33'h0);
        apb(1'b0, 16'h0003, 32'h0, {1'b1, 32'h0});
        run_mode(tdm_port_pkg::MODE_1X6, 1'b0, 6);
        run_mode(tdm_port_pkg::MODE_1X6, 1'b1, 6);
        run_mode(tdm_port_pkg::MODE_1X12, 1'b1, 12);
        run_mode(tdm_port_pkg::MODE_2X32, 1'b0, 32);
        run_mode(tdm_port_pkg::MODE_1X64, 1'b0, 64);
        give_verdict();
    end
endmodule : tb_tdm_port_frame_double_buffer
`default_nettype wire

// ### tb/tdm_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module tdm_far_side (
    output logic o_bit_clock,       // Bit clock to the port
    output logic o_frame_sync,      // Frame sync to the port
    output logic o_up0,             // Upstream data, port 0
    output logic o_up1,             // Upstream data, port 1
    input wire logic i_dd0,         // Downstream wire level, port 0
    input wire logic i_dd1,         // Downstream wire level, port 1
    input wire logic i_run,         // Clock runs while high
    input wire logic i_dbl,         // Two clocks per bit
    input wire logic [9:0] i_nbits  // Bits per frame
);
    int frame = 0;
    event fstart;
    logic [15:0] cap_q[$];
    logic [7:0] sh0 = 8'h00;
    logic [7:0] sh1 = 8'h00;
    function automatic logic [7:0] upb(input int f, input int k,
                                       input logic p);
        return 8'(f * 7 + k * 3) ^ (p ? 8'hc3 : 8'h5a);
    endfunction : upb
    initial begin
        int n;
        int b;
        logic d;
        logic [7:0] u0;
        logic [7:0] u1;
        o_bit_clock = 1'b1;
        o_frame_sync = 1'b0;
        o_up0 = 1'b1;
        o_up1 = 1'b1;
        #13;
        forever begin
            if (i_run !== 1'b1) begin
                // Clock stands still; pulled-up lines idle at 1
                o_up0 = 1'b1;
                o_up1 = 1'b1;
                #400;
            end else begin
                d = i_dbl;
                n = d ? 2 * i_nbits : i_nbits;
                for (int j = 0; j < n; j++) begin
                    b = d ? j / 2 : j;
                    o_bit_clock = 1'b1;
                    o_frame_sync = (j == 0);
                    if (j == 0) begin
                        frame++;
                        -> fstart;
                    end
                    if (!d || j % 2 == 0) begin
                        u0 = upb(frame, b / 8, 1'b0);
                        u1 = upb(frame, b / 8, 1'b1);
                        o_up0 = u0[7 - b % 8];
                        o_up1 = u1[7 - b % 8];
                    end
                    #400;
                    o_bit_clock = 1'b0;
                    if (!d || j % 2 == 1) begin
                        sh0 = {sh0[6:0], i_dd0};
                        sh1 = {sh1[6:0], i_dd1};
                        if (b % 8 == 7) cap_q.push_back({sh1, sh0});
                    end
                    #400;
                end
            end
        end
    end
endmodule : tdm_far_side
`default_nettype wire

// ### verilog/tdm_port_frame_double_buffer.sv
`timescale 1ns/1ns
`default_nettype none

module tdm_byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,                 // Block clock
    input wire logic i_arst_n,              // Asynchronous reset, low
    input wire logic i_wvalid,              // Fill side has a word
    input wire logic [WIDTH-1:0] i_wdata,   // Fill side word
    output logic o_wready,                  // Room for a word
    output logic o_rvalid,                  // Drain side has a word
    output logic [WIDTH-1:0] o_rdata,       // Oldest word
    input wire logic i_rready               // Drain side takes the word
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic push;
    logic pop;

    assign o_wready = cnt != CW'(DEPTH);
    assign o_rvalid = cnt != '0;
    assign o_rdata = store[rp];
    assign push = i_wvalid && o_wready;
    assign pop = o_rvalid && i_rready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wp] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule : tdm_byte_fifo

// What this block does
// - Two frame buffers swap serial and processor roles every frame.
// - Two-port mode puts rx 0/1 at 0x00/0x20 and tx 0/1 at 0x40/0x60.
// - Single-port modes put receive slots at 0x00 and transmit at 0x40.
// - Processor sees rx slot k at 0x8000+k and tx slot k at 0x8040+k.
// - Processor accesses always reach the buffer in processor role.
// - Serial side fills and drains frame n while processor has n-1/n+1.
// - Frames carry 6, 12, 32 or 64 slots as selected by the mode.
// - In 64-slot mode port 1 is idle with its output released.
// - Single rate drives on the rising and samples on the falling edge.
// - Frame sync is sampled on falling edges; a 0 then 1 starts a frame.
// - Double rate drives on every second rising, samples second falling.
// - Slots are shifted most significant bit first in both directions.
// - Buffer reads return the slot in the low byte and prefix above it.
// - Buffer writes keep only the low eight bits of the data.
module tdm_port_frame_double_buffer (
    input wire logic I_MCLK,                     // Block clock, 10 MHz
    input wire logic I_ARST_N,                   // Asynchronous reset, low
    input wire logic I_PSEL,                     // APB select
    input wire logic I_PENABLE,                  // APB access phase
    input wire logic I_PWRITE,                   // APB write
    input wire logic [17:0] I_PADDR,             // APB byte address
    input wire logic [31:0] I_PWDATA,            // APB write data
    output logic [31:0] O_PRDATA,                // APB read data
    output logic O_PREADY,                       // APB ready
    output logic O_PSLVERR,                      // APB unmapped address
    input wire logic I_BIT_CLOCK,                // Serial bit clock
    input wire logic I_FRAME_SYNC,               // Serial frame sync
    input wire logic I_UPSTREAM_DATA_0,          // Port 0 serial input
    input wire logic I_UPSTREAM_DATA_1,          // Port 1 serial input
    output logic O_DOWNSTREAM_DATA_0,            // Port 0 serial output
    output logic O_DOWNSTREAM_DATA_0_OE_N,       // Port 0 drive enable, low
    output logic O_DOWNSTREAM_DATA_1,            // Port 1 serial output
    output logic O_DOWNSTREAM_DATA_1_OE_N        // Port 1 drive enable, low
);
    logic [2:0] clk_sync;
    logic [1:0] fs_sync, du0_sync, du1_sync;
    tdm_port_pkg::port_mode_t mode;
    logic dbl, ovr, locked, fs_prev, sbuf;
    logic [7:0] prefix;
    logic [9:0] pos;
    logic [7:0] mem [0:255];
    logic [6:0] rxsh0, rxsh1;
    logic [7:0] txbyte0, txbyte1;
    logic pend0_v, pend1_v;
    logic [15:0] pend0, pend1;

    // Inputs from the far side pass two flops; edges use stages 1 and 2
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            clk_sync <= 3'h7; // Idle-high clock: no edge after reset
            fs_sync <= 2'h0;
            du0_sync <= 2'h3;
            du1_sync <= 2'h3;
        end else begin
            clk_sync <= {clk_sync[1:0], I_BIT_CLOCK};
            fs_sync <= {fs_sync[0], I_FRAME_SYNC};
            du0_sync <= {du0_sync[0], I_UPSTREAM_DATA_0};
            du1_sync <= {du1_sync[0], I_UPSTREAM_DATA_1};
        end
    end

    logic bc_fall, bc_rise, dbl_eff, dual, fs_start, samp, tdrive;
    logic [9:0] last_ph, ph_cur;
    logic [8:0] rbidx, tbidx;

    assign bc_fall = clk_sync[2] && !clk_sync[1];
    assign bc_rise = !clk_sync[2] && clk_sync[1];
    // Double rate is refused at 64 slots; that mode always runs single
    assign dbl_eff = dbl && (mode != tdm_port_pkg::MODE_1X64);
    assign dual = mode == tdm_port_pkg::MODE_2X32;
    assign last_ph = tdm_port_pkg::last_phase(mode, dbl_eff);
    assign fs_start = bc_fall && fs_sync[1] && !fs_prev;
    assign ph_cur = fs_start ? 10'h000 : pos;
    assign rbidx = dbl_eff ? ph_cur[9:1] : ph_cur[8:0];
    assign tbidx = dbl_eff ? pos[9:1] : pos[8:0];
    assign samp = bc_fall && (!dbl_eff || ph_cur[0]);
    assign tdrive = bc_rise && (!dbl_eff || !pos[0]);

    // Phase counter and buffer swap; swapping at the wrap lets the first
    // byte of the next frame be fetched from the fresh buffer
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pos <= 10'h000;
            sbuf <= 1'b0;
            fs_prev <= 1'b0;
            locked <= 1'b0;
        end else if (bc_fall) begin
            fs_prev <= fs_sync[1];
            if (fs_start) begin
                locked <= 1'b1;
                pos <= tdm_port_pkg::PH_AFTER_SYNC;
                if (pos != 10'h000) begin
                    sbuf <= !sbuf;
                end
            end else if (pos >= last_ph) begin
                pos <= 10'h000;
                sbuf <= !sbuf;
            end else begin
                pos <= pos + 10'h001;
            end
        end
    end

    logic [6:0] rx_addr0, rx_addr1, tx_addr0, tx_addr1;
    logic [7:0] tx_src0, tx_src1;
    assign rx_addr0 = tdm_port_pkg::slot_addr(mode, 1'b0, 1'b0, rbidx[8:3]);
    assign rx_addr1 = tdm_port_pkg::slot_addr(mode, 1'b1, 1'b0, rbidx[8:3]);
    assign tx_addr0 = tdm_port_pkg::slot_addr(mode, 1'b0, 1'b1, tbidx[8:3]);
    assign tx_addr1 = tdm_port_pkg::slot_addr(mode, 1'b1, 1'b1, tbidx[8:3]);
    assign tx_src0 = mem[{sbuf, tx_addr0}];
    assign tx_src1 = mem[{sbuf, tx_addr1}];

    // Transmit, bit 7 first; the slot byte is latched at its first bit
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_DOWNSTREAM_DATA_0 <= 1'b1;
            O_DOWNSTREAM_DATA_1 <= 1'b1;
            O_DOWNSTREAM_DATA_0_OE_N <= 1'b1;
            O_DOWNSTREAM_DATA_1_OE_N <= 1'b1;
            txbyte0 <= 8'hff;
            txbyte1 <= 8'hff;
        end else begin
            O_DOWNSTREAM_DATA_0_OE_N <= 1'b0;
            O_DOWNSTREAM_DATA_1_OE_N <= !dual;
            if (!dual) begin
                O_DOWNSTREAM_DATA_1 <= 1'b1;
            end
            if (tdrive) begin
                if (tbidx[2:0] == 3'h0) begin
                    txbyte0 <= tx_src0;
                    O_DOWNSTREAM_DATA_0 <= tx_src0[7];
                    if (dual) begin
                        txbyte1 <= tx_src1;
                        O_DOWNSTREAM_DATA_1 <= tx_src1[7];
                    end
                end else begin
                    O_DOWNSTREAM_DATA_0 <= txbyte0[~tbidx[2:0]];
                    if (dual) begin
                        O_DOWNSTREAM_DATA_1 <= txbyte1[~tbidx[2:0]];
                    end
                end
            end
        end
    end

    logic fifo_wready, fifo_rvalid, fifo_rready, push0, push1, byte_done;
    logic [15:0] fifo_rdata;
    assign byte_done = samp && rbidx[2:0] == tdm_port_pkg::BIT_LAST;
    assign push0 = pend0_v && fifo_wready;
    assign push1 = !pend0_v && pend1_v && fifo_wready;

    // Receive, bit 7 first; finished bytes wait here for the FIFO, which
    // stalls them while processor writes hold the buffer write port
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rxsh0 <= 7'h00;
            rxsh1 <= 7'h00;
            pend0_v <= 1'b0;
            pend1_v <= 1'b0;
            pend0 <= 16'h0000;
            pend1 <= 16'h0000;
        end else begin
            if (push0) begin
                pend0_v <= 1'b0;
            end
            if (push1) begin
                pend1_v <= 1'b0;
            end
            if (samp) begin
                rxsh0 <= {rxsh0[5:0], du0_sync[1]};
                rxsh1 <= {rxsh1[5:0], du1_sync[1]};
            end
            if (byte_done) begin
                pend0_v <= 1'b1;
                pend0 <= {sbuf, rx_addr0, rxsh0, du0_sync[1]};
                if (dual) begin
                    pend1_v <= 1'b1;
                    pend1 <= {sbuf, rx_addr1, rxsh1, du1_sync[1]};
                end
            end
        end
    end

    tdm_byte_fifo #(
        .WIDTH(tdm_port_pkg::FIFO_WIDTH),
        .DEPTH(tdm_port_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .i_wvalid(pend0_v || pend1_v),
        .i_wdata(pend0_v ? pend0 : pend1),
        .o_wready(fifo_wready),
        .o_rvalid(fifo_rvalid),
        .o_rdata(fifo_rdata),
        .i_rready(fifo_rready)
    );

    logic acc, done, in_win, mapped, apb_mem_wr;
    logic [15:0] idx;
    logic [7:0] win_idx, win_byte;
    logic [31:0] rd_val;
    assign acc = I_PSEL && I_PENABLE;
    assign done = acc && O_PREADY;
    assign idx = I_PADDR[17:2];
    assign in_win = idx >= tdm_port_pkg::IDX_WIN_FIRST
                 && idx <= tdm_port_pkg::IDX_WIN_LAST;
    assign mapped = in_win || idx == tdm_port_pkg::IDX_CTRL
                 || idx == tdm_port_pkg::IDX_PREFIX
                 || idx == tdm_port_pkg::IDX_STATUS;
    assign win_idx = {!sbuf, idx[6:0]};
    assign win_byte = mem[win_idx];
    // Receive half of the window is read only
    assign apb_mem_wr = done && I_PWRITE && in_win && idx[6];
    assign fifo_rready = !apb_mem_wr;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (in_win) begin
            rd_val = {16'h0000, prefix, win_byte};
        end else if (idx == tdm_port_pkg::IDX_CTRL) begin
            rd_val = {29'h0000_0000, dbl, mode};
        end else if (idx == tdm_port_pkg::IDX_PREFIX) begin
            rd_val = {24'h00_0000, prefix};
        end else if (idx == tdm_port_pkg::IDX_STATUS) begin
            rd_val = {29'h0000_0000, ovr, locked, sbuf};
        end
    end

    // Processor writes win the single write port over received bytes
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (apb_mem_wr) begin
            mem[win_idx] <= I_PWDATA[7:0];
        end else if (fifo_rvalid) begin
            mem[fifo_rdata[15:8]] <= fifo_rdata[7:0];
        end
    end

    // One wait state on every access
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= acc && !O_PREADY;
            if (acc && !O_PREADY) begin
                O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_val;
                O_PSLVERR <= !mapped;
            end
        end
    end

    // Overrun: a byte finished while its predecessor still waited
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mode <= tdm_port_pkg::MODE_RESET;
            dbl <= 1'b0;
            prefix <= tdm_port_pkg::PREFIX_RESET;
            ovr <= 1'b0;
        end else begin
            if (done && I_PWRITE && idx == tdm_port_pkg::IDX_CTRL) begin
                mode <= tdm_port_pkg::port_mode_t'(I_PWDATA[1:0]);
                dbl <= I_PWDATA[tdm_port_pkg::CTRL_DBL];
            end
            if (done && I_PWRITE && idx == tdm_port_pkg::IDX_PREFIX) begin
                prefix <= I_PWDATA[7:0];
            end
            if (done && I_PWRITE && idx == tdm_port_pkg::IDX_STATUS
                && I_PWDATA[tdm_port_pkg::STAT_OVR]) begin
                ovr <= 1'b0;
            end
            if (byte_done && (pend0_v && !push0 || pend1_v && !push1)) begin
                ovr <= 1'b1;
            end
        end
    end

    a_ready_pulse: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
        O_PREADY |=> !O_PREADY)
        else $error("ready held longer than one cycle");
    a_swap_each_frame: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        (bc_fall && !fs_start && pos >= last_ph) |=> sbuf != $past(sbuf))
        else $error("buffers not swapped at frame end");
    a_read_steered: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        (acc && !O_PREADY && !I_PWRITE && in_win)
        |=> O_PRDATA[7:0] == $past(mem[{!sbuf, idx[6:0]}]))
        else $error("read not taken from processor buffer");
    a_read_prefix: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        (acc && !O_PREADY && !I_PWRITE && in_win)
        |=> O_PRDATA[15:8] == prefix && O_PRDATA[31:16] == 16'h0000)
        else $error("read high byte is not the prefix");
    a_write_low_byte: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        apb_mem_wr |=> mem[$past(win_idx)] == $past(I_PWDATA[7:0]))
        else $error("buffer write lost its low byte");
    a_port1_idle: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        mode == tdm_port_pkg::MODE_1X64
        |=> O_DOWNSTREAM_DATA_1_OE_N && O_DOWNSTREAM_DATA_1)
        else $error("port 1 not released in 64-slot mode");
    a_sync_restart: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        fs_start |=> pos == tdm_port_pkg::PH_AFTER_SYNC)
        else $error("frame start did not realign phase");
    a_dbl_hold: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        (bc_rise && dbl_eff && pos[0]) |=> $stable(O_DOWNSTREAM_DATA_0))
        else $error("output changed mid-bit in double rate");
    a_msb_first: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        (tdrive && tbidx[2:0] == 3'h0)
        |=> O_DOWNSTREAM_DATA_0 == $past(tx_src0[7]))
        else $error("slot did not start with bit 7");
    a_rx_byte_kept: assert property (@(posedge I_MCLK)
        disable iff (!I_ARST_N)
        byte_done |=> pend0_v && pend0[15] == $past(sbuf))
        else $error("received byte not queued for serial buffer");
endmodule : tdm_port_frame_double_buffer

`default_nettype wire
